// ===== src/txps_params.svh
// Offsets, field positions, reset values and counts of the pulse shaper and line monitor
`ifndef TXPS_PARAMS_SVH
`define TXPS_PARAMS_SVH

// Register byte offsets
`define TXPS_OFF_CTRL 8'h00
`define TXPS_OFF_LEGACY 8'h04
`define TXPS_OFF_LSTAT 8'h08
`define TXPS_OFF_IRQ_STAT 8'h0c
`define TXPS_OFF_IRQ_MASK 8'h10
`define TXPS_AMP_PAGE 2'h1

// Control register fields
`define TXPS_CTRL_SEL 0
`define TXPS_CTRL_ATD 1
`define TXPS_CTRL_T1 2
`define TXPS_CTRL_LBO 3

// Line status and interrupt fields
`define TXPS_ST_ONES 0
`define TXPS_ST_HC 1
`define TXPS_ST_HIZ 2

// Reset values
`define TXPS_LEG0_RST 8'h7b
`define TXPS_LEG1_RST 8'h03
`define TXPS_LEG2_RST 8'h40
`define TXPS_AMP_LO_RST 8'h38
`define TXPS_AMP_HI_RST 8'h00

// Built-in T1 short-range shape used ahead of the attenuator
`define TXPS_T1S_B0 8'hd7
`define TXPS_T1S_B1 8'h22
`define TXPS_T1S_B2 8'h11

// Monitor thresholds
`define TXPS_HC_PULSES 2'h3
`define TXPS_ZERO_LIMIT 6'h1f

`endif

// ===== src/txps_pkg.sv
// Types shared by the pulse shaper, the top level and the bench
package txps_pkg;
    typedef logic signed [7:0] txps_amp_t;
    typedef enum {TXPS_LEGACY, TXPS_LEGACY_LBO, TXPS_TABLE} txps_mode_t;
endpackage

// ===== src/txps_shaper.sv
// Pulse shape generation from legacy bytes, the built-in T1 shape under attenuation, or the per-sample amplitude table
`timescale 1ns/1ps
`default_nettype none
`include "txps_params.svh"
module txps_shaper import txps_pkg::*; #(
    parameter int NSAMP = 16
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic sym_strobe,
    input wire logic samp_strobe,
    input wire logic tx_mark,
    input wire logic pulse_table_select,
    input wire logic t1_mode,
    input wire logic [1:0] lbo_field,
    input wire logic [23:0] legacy_bytes,
    input wire txps_amp_t amp_tbl [NSAMP],
    output txps_mode_t shape_mode,
    output txps_amp_t sample_level,
    output logic [1:0] line_buildout_atten,
    output logic [23:0] legacy_coef,
    output logic tx_line_out_a,
    output logic tx_line_out_b
);
    localparam int IW = $clog2(NSAMP);
    logic [$clog2(NSAMP)-1:0] idx_ff;
    logic mark_ff;
    logic pol_ff;
    logic [1:0] lbo_eff;
    txps_mode_t nxt_mode;

    // Attenuation only exists in T1 mode; zero means none
    assign lbo_eff = t1_mode ? lbo_field : 2'h0;

    // Source of the shape
    always_comb begin
        if (pulse_table_select) begin
            nxt_mode = TXPS_TABLE;
        end else if (lbo_eff != 2'h0) begin
            nxt_mode = TXPS_LEGACY_LBO;
        end else begin
            nxt_mode = TXPS_LEGACY;
        end
    end

    // Sample index and alternating mark polarity
    always_ff @(posedge clock) begin
        if (!rstn) begin
            idx_ff <= '0;
            mark_ff <= 1'b0;
            pol_ff <= 1'b0;
        end else if (sym_strobe) begin
            idx_ff <= '0;
            mark_ff <= tx_mark;
            if (tx_mark) begin
                pol_ff <= ~pol_ff;
            end
        end else if (samp_strobe) begin
            idx_ff <= idx_ff + IW'(1);
        end
    end

    // Shaped outputs; the attenuator setting passes on in every mode
    always_ff @(posedge clock) begin
        if (!rstn) begin
            shape_mode <= TXPS_LEGACY;
            sample_level <= '0;
            line_buildout_atten <= 2'h0;
            legacy_coef <= '0;
            tx_line_out_a <= 1'b0;
            tx_line_out_b <= 1'b0;
        end else begin
            shape_mode <= nxt_mode;
            line_buildout_atten <= lbo_eff;
            tx_line_out_a <= mark_ff & pol_ff;
            tx_line_out_b <= mark_ff & ~pol_ff;
            case (nxt_mode)
                TXPS_TABLE: begin
                    legacy_coef <= '0;
                    // Signed entries; the second mark polarity inverts them
                    if (!mark_ff) begin
                        sample_level <= '0;
                    end else if (pol_ff) begin
                        sample_level <= amp_tbl[idx_ff];
                    end else begin
                        sample_level <= -amp_tbl[idx_ff];
                    end
                end
                TXPS_LEGACY_LBO: begin
                    sample_level <= '0;
                    legacy_coef <= {`TXPS_T1S_B2, `TXPS_T1S_B1, `TXPS_T1S_B0};
                end
                default: begin
                    sample_level <= '0;
                    legacy_coef <= legacy_bytes;
                end
            endcase
        end
    end

    a_lbo_override: assert property (@(posedge clock) disable iff (!rstn)
        (!pulse_table_select && t1_mode && lbo_field != 2'h0)
        |=> legacy_coef == 24'h1122d7)
        else $error("Built-in T1 shape not used under attenuation");
    a_atten_t1_only: assert property (@(posedge clock) disable iff (!rstn)
        !t1_mode |=> line_buildout_atten == 2'h0)
        else $error("Attenuation active outside T1 mode");
endmodule
`default_nettype wire

// ===== src/txps_monitor.sv
// Transmit line monitor: zero runs, over-current and driver tri-state
`timescale 1ns/1ps
`default_nettype none
`include "txps_params.svh"
module txps_monitor (
    input wire logic clock,
    input wire logic rstn,
    input wire logic sym_strobe,
    input wire logic tx_mark,
    input wire logic over_current,
    input wire logic auto_tristate_disable,
    output logic tx_ones_density_fault,
    output logic tx_high_current_fault,
    output logic driver_hiz,
    output logic ones_change,
    output logic hc_change
);
    logic [5:0] zero_cnt_ff;
    logic [1:0] hc_cnt_ff;
    logic ones_prev_ff;
    logic hc_prev_ff;

    // Zero run counter, restarted by every mark
    always_ff @(posedge clock) begin
        if (!rstn) begin
            zero_cnt_ff <= '0;
            tx_ones_density_fault <= 1'b0;
        end else if (sym_strobe) begin
            if (tx_mark) begin
                zero_cnt_ff <= '0;
                tx_ones_density_fault <= 1'b0;
            end else begin
                if (zero_cnt_ff != 6'h3f) begin
                    zero_cnt_ff <= zero_cnt_ff + 6'h1;
                end
                if (zero_cnt_ff >= `TXPS_ZERO_LIMIT) begin
                    tx_ones_density_fault <= 1'b1;
                end
            end
        end
    end

    // Consecutive over-current pulses; released as soon as current drops
    always_ff @(posedge clock) begin
        if (!rstn) begin
            hc_cnt_ff <= '0;
        end else if (!over_current) begin
            hc_cnt_ff <= '0;
        end else if (sym_strobe && tx_mark && hc_cnt_ff != `TXPS_HC_PULSES) begin
            hc_cnt_ff <= hc_cnt_ff + 2'h1;
        end
    end

    assign tx_high_current_fault = (hc_cnt_ff == `TXPS_HC_PULSES);
    assign driver_hiz = tx_high_current_fault & ~auto_tristate_disable;

    // Change detection for the interrupt
    always_ff @(posedge clock) begin
        if (!rstn) begin
            ones_prev_ff <= 1'b0;
            hc_prev_ff <= 1'b0;
        end else begin
            ones_prev_ff <= tx_ones_density_fault;
            hc_prev_ff <= tx_high_current_fault;
        end
    end

    assign ones_change = ones_prev_ff ^ tx_ones_density_fault;
    assign hc_change = hc_prev_ff ^ tx_high_current_fault;

    a_zero_fault_set: assert property (@(posedge clock) disable iff (!rstn)
        (sym_strobe && !tx_mark && zero_cnt_ff == 6'h1f) |=> tx_ones_density_fault)
        else $error("Ones-density fault missing after 32 zeros");
    a_mark_clears: assert property (@(posedge clock) disable iff (!rstn)
        (sym_strobe && tx_mark) |=> (!tx_ones_density_fault && zero_cnt_ff == 6'h0))
        else $error("Mark did not clear zero run");
    a_hc_three: assert property (@(posedge clock) disable iff (!rstn)
        $rose(tx_high_current_fault) |-> $past(sym_strobe && tx_mark && over_current))
        else $error("High current declared without third pulse");
    a_hiz_release: assert property (@(posedge clock) disable iff (!rstn)
        (driver_hiz && !over_current) |=> !driver_hiz)
        else $error("Driver not released after current drop");
endmodule
`default_nettype wire

// ===== src/txps_top.sv
// AXI4-Lite register file, interrupt and wiring of the pulse shaper and line monitor
`timescale 1ns/1ps
`default_nettype none
`include "txps_params.svh"

////////////////////////////////////////////////////////////////////////////////

module txps_top import txps_pkg::*; #(
    parameter int NSAMP = 16
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic sym_strobe,
    input wire logic samp_strobe,
    input wire logic tx_mark,
    input wire logic over_current,
    output logic irq,
    output txps_mode_t shape_mode,
    output txps_amp_t sample_level,
    output logic [1:0] line_buildout_atten,
    output logic [23:0] legacy_coef,
    output logic tx_line_out_a,
    output logic tx_line_out_b,
    output logic tx_line_oe
);

    ////////////////////////////////////////////////////////////////////////////////

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // True for an address in the sample amplitude page
    function automatic logic is_amp(input logic [7:0] a);
        return a[7:6] == `TXPS_AMP_PAGE;
    endfunction

    // Byte lane merge under a write strobe
    function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] nw,
                                          input logic strb);
        return strb ? nw : old;
    endfunction

    logic aw_held_ff;
    logic w_held_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic do_write;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_word;
    logic rd_take;

    logic pulse_table_select_ff;
    logic auto_tristate_disable_ff;
    logic t1_mode_ff;
    logic [1:0] lbo_ff;
    logic [7:0] leg_ff [3];
    txps_amp_t amp_ff [NSAMP];
    logic [1:0] irq_stat_ff;
    logic [1:0] irq_mask_ff;
    logic [2:0] line_status_reg;

    logic tx_ones_density_fault;
    logic tx_high_current_fault;
    logic driver_hiz;
    logic ones_change;
    logic hc_change;

    ////////////////////////////////////////////////////////////////////////////////

    // Write channels taken in either order, one write under way at a time
    assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
    assign s_axi_wready = !w_held_ff && !s_axi_bvalid;
    assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            aw_held_ff <= 1'b0;
            awaddr_ff <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            w_held_ff <= 1'b0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_ff <= 1'b0;
        end
    end

    // Address decode for writes
    always_comb begin
        case (awaddr_ff)
            `TXPS_OFF_CTRL, `TXPS_OFF_LEGACY, `TXPS_OFF_IRQ_MASK: wr_hit = 1'b1;
            default: wr_hit = is_amp(awaddr_ff) && awaddr_ff[1:0] == 2'h0;
        endcase
    end

    // Write response
    always_ff @(posedge clock) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    // Control bits; reset picks the legacy set and auto tri-state on
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pulse_table_select_ff <= 1'b0;
            auto_tristate_disable_ff <= 1'b0;
            t1_mode_ff <= 1'b0;
            lbo_ff <= 2'h0;
            irq_mask_ff <= 2'h0;
        end else if (do_write && wstrb_ff[0]) begin
            if (awaddr_ff == `TXPS_OFF_CTRL) begin
                pulse_table_select_ff <= wdata_ff[`TXPS_CTRL_SEL];
                auto_tristate_disable_ff <= wdata_ff[`TXPS_CTRL_ATD];
                t1_mode_ff <= wdata_ff[`TXPS_CTRL_T1];
                lbo_ff <= wdata_ff[`TXPS_CTRL_LBO+1:`TXPS_CTRL_LBO];
            end
            if (awaddr_ff == `TXPS_OFF_IRQ_MASK) begin
                irq_mask_ff <= wdata_ff[1:0];
            end
        end
    end

    // Legacy shape bytes, reset to an unreduced E1 pulse
    always_ff @(posedge clock) begin
        if (!rstn) begin
            leg_ff[0] <= `TXPS_LEG0_RST;
            leg_ff[1] <= `TXPS_LEG1_RST;
            leg_ff[2] <= `TXPS_LEG2_RST;
        end else if (do_write && awaddr_ff == `TXPS_OFF_LEGACY) begin
            for (int i = 0; i < 3; i++) begin
                leg_ff[i] <= merge8(leg_ff[i], wdata_ff[8*i +: 8], wstrb_ff[i]);
            end
        end
    end

    // Sample amplitude table; first half at full E1 level, rest zero
    always_ff @(posedge clock) begin
        if (!rstn) begin
            for (int i = 0; i < NSAMP; i++) begin
                amp_ff[i] <= (i < NSAMP / 2) ? `TXPS_AMP_LO_RST : `TXPS_AMP_HI_RST;
            end
        end else if (do_write && is_amp(awaddr_ff) && awaddr_ff[1:0] == 2'h0) begin
            amp_ff[awaddr_ff[5:2]] <= merge8(amp_ff[awaddr_ff[5:2]], wdata_ff[7:0],
                                             wstrb_ff[0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    // Line status view of the monitor
    assign line_status_reg[`TXPS_ST_ONES] = tx_ones_density_fault;
    assign line_status_reg[`TXPS_ST_HC] = tx_high_current_fault;
    assign line_status_reg[`TXPS_ST_HIZ] = driver_hiz;

    // Read data and decode
    always_comb begin
        rd_word = 32'h0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `TXPS_OFF_CTRL: rd_word = {27'h0, lbo_ff, t1_mode_ff, auto_tristate_disable_ff,
                                       pulse_table_select_ff};
            `TXPS_OFF_LEGACY: rd_word = {8'h0, leg_ff[2], leg_ff[1], leg_ff[0]};
            `TXPS_OFF_LSTAT: rd_word = {29'h0, line_status_reg};
            `TXPS_OFF_IRQ_STAT: rd_word = {30'h0, irq_stat_ff};
            `TXPS_OFF_IRQ_MASK: rd_word = {30'h0, irq_mask_ff};
            default: begin
                if (is_amp(s_axi_araddr) && s_axi_araddr[1:0] == 2'h0) begin
                    rd_word = {{24{amp_ff[s_axi_araddr[5:2]][7]}}, amp_ff[s_axi_araddr[5:2]]};
                end else begin
                    rd_hit = 1'b0;
                end
            end
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;
    assign rd_take = s_axi_arvalid && s_axi_arready;

    // Read response, one cycle after the address is taken
    always_ff @(posedge clock) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    // Sticky change bits; a read clears them but a same-cycle event wins
    always_ff @(posedge clock) begin
        if (!rstn) begin
            irq_stat_ff <= 2'h0;
        end else begin
            irq_stat_ff <= ((rd_take && s_axi_araddr == `TXPS_OFF_IRQ_STAT) ? 2'h0 : irq_stat_ff)
                           | {hc_change, ones_change};
        end
    end

    assign irq = |(irq_stat_ff & irq_mask_ff);
    assign tx_line_oe = !driver_hiz;

    ////////////////////////////////////////////////////////////////////////////////

    txps_shaper #(
        .NSAMP(NSAMP)
    ) u_shaper (
        .clock(clock),
        .rstn(rstn),
        .sym_strobe(sym_strobe),
        .samp_strobe(samp_strobe),
        .tx_mark(tx_mark),
        .pulse_table_select(pulse_table_select_ff),
        .t1_mode(t1_mode_ff),
        .lbo_field(lbo_ff),
        .legacy_bytes({leg_ff[2], leg_ff[1], leg_ff[0]}),
        .amp_tbl(amp_ff),
        .shape_mode(shape_mode),
        .sample_level(sample_level),
        .line_buildout_atten(line_buildout_atten),
        .legacy_coef(legacy_coef),
        .tx_line_out_a(tx_line_out_a),
        .tx_line_out_b(tx_line_out_b)
    );

    txps_monitor u_monitor (
        .clock(clock),
        .rstn(rstn),
        .sym_strobe(sym_strobe),
        .tx_mark(tx_mark),
        .over_current(over_current),
        .auto_tristate_disable(auto_tristate_disable_ff),
        .tx_ones_density_fault(tx_ones_density_fault),
        .tx_high_current_fault(tx_high_current_fault),
        .driver_hiz(driver_hiz),
        .ones_change(ones_change),
        .hc_change(hc_change)
    );

    ////////////////////////////////////////////////////////////////////////////////

    a_reset_legacy: assert property (@(posedge clock)
        !rstn |=> (!pulse_table_select_ff && leg_ff[0] == 8'h7b && leg_ff[2] == 8'h40))
        else $error("Reset did not restore legacy shape");
    a_reset_table: assert property (@(posedge clock)
        !rstn |=> (amp_ff[0] == 8'sh38 && amp_ff[7] == 8'sh38 && amp_ff[8] == 8'sh00))
        else $error("Reset did not restore sample table");
    a_table_mode: assert property (@(posedge clock) disable iff (!rstn)
        pulse_table_select_ff |=> shape_mode == TXPS_TABLE)
        else $error("Table select ignored");
    a_hc_status: assert property (@(posedge clock) disable iff (!rstn)
        (rd_take && s_axi_araddr == `TXPS_OFF_LSTAT)
        |=> s_axi_rdata[`TXPS_ST_HC] == $past(tx_high_current_fault))
        else $error("High-current status bit wrong");
    a_irq_on_change: assert property (@(posedge clock) disable iff (!rstn)
        (ones_change && irq_mask_ff[0]) |=> irq)
        else $error("No interrupt on ones-density change");
    a_tristate: assert property (@(posedge clock) disable iff (!rstn)
        (tx_high_current_fault && !auto_tristate_disable_ff) |-> !tx_line_oe)
        else $error("Driver enabled during high current");

endmodule
`default_nettype wire

// ===== testbench/txps_line_model.sv
// Behavioural line side: symbol timing, marks and driver over-current
`timescale 1ns/1ps
`default_nettype none
module txps_line_model (
    input wire logic clock,
    input wire logic rstn,
    input wire logic send_mark,
    input wire logic short_load,
    output logic sym_strobe,
    output logic samp_strobe,
    output logic tx_mark,
    output logic over_current
);
    logic [3:0] samp_ff;
    ////////////////////////////////////////
    // Sixteen sample points per symbol; a shorted primary draws current on every cycle, marks or not
    always_ff @(posedge clock) begin
        if (!rstn) begin
            samp_ff <= 4'h0;
            sym_strobe <= 1'b0;
            samp_strobe <= 1'b0;
            tx_mark <= 1'b0;
            over_current <= 1'b0;
        end else begin
            samp_ff <= samp_ff + 4'h1;
            samp_strobe <= 1'b1;
            sym_strobe <= (samp_ff == 4'hf);
            if (samp_ff == 4'hf) begin
                tx_mark <= send_mark;
            end
            over_current <= short_load;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the pulse shaper and line monitor
`timescale 1ns/1ps
`default_nettype none
`include "txps_params.svh"
module testbench import txps_pkg::*;;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rd_data, rdata;
    logic [1:0] rd_resp, bresp, rresp, atten;
    logic send_mark = 1'b1, short_load = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, oe;
    logic sym_strobe, samp_strobe, tx_mark, over_current;
    txps_mode_t shape_mode;
    logic [23:0] coef;
    logic [7:0] level;
    logic la, lb;
    int err_count = 0, samples_checked = 0;
    txps_top uut (.clock(clock), .rstn(rstn), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .sym_strobe(sym_strobe), .samp_strobe(samp_strobe),
        .tx_mark(tx_mark), .over_current(over_current), .irq(irq),
        .shape_mode(shape_mode), .sample_level(level), .line_buildout_atten(atten),
        .legacy_coef(coef), .tx_line_out_a(la), .tx_line_out_b(lb), .tx_line_oe(oe));
    txps_line_model line (.clock(clock), .rstn(rstn), .send_mark(send_mark),
        .short_load(short_load), .sym_strobe(sym_strobe), .samp_strobe(samp_strobe),
        .tx_mark(tx_mark), .over_current(over_current));
    ////////////////////////////////////////
    // Clock and shared tasks
    always #12.5 clock = ~clock;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge clock);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        do begin
            @(negedge clock);
            ta = ta || (awready && awvalid);
            tw = tw || (wready && wvalid);
            @(posedge clock);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!(ta && tw));
        do @(negedge clock); while (!bvalid);
        chk("bresp", 32'h0, bresp);
        @(posedge clock);
        bready <= 1'b0;
        @(negedge clock);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(negedge clock); while (!arready);
        @(posedge clock);
        arvalid <= 1'b0;
        do @(negedge clock); while (!rvalid);
        rd_data = rdata;
        rd_resp = rresp;
        @(posedge clock);
        rready <= 1'b0;
        @(negedge clock);
    endtask
    task automatic syms(input int n);
        repeat (n) do @(posedge clock); while (!sym_strobe);
    endtask
    // Settle two edges after a symbol, then read line status
    task automatic lstat(input logic [31:0] exp);
        repeat (2) @(posedge clock);
        rd(`TXPS_OFF_LSTAT);
        chk("line status", exp, rd_data);
    endtask
    ////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        chk("mode", TXPS_LEGACY, shape_mode);
        chk("coef", 32'h40037b, coef);
        rd(`TXPS_OFF_CTRL);
        chk("ctrl", 32'h0, rd_data);
        rd(`TXPS_OFF_LEGACY);
        chk("legacy", 32'h40037b, rd_data);
        rd(8'h5c);
        chk("amp8", 32'h38, rd_data);
        rd(8'h60);
        chk("amp9", 32'h0, rd_data);
        rd(8'h30);
        chk("unmapped resp", 32'h2, rd_resp);
    endtask
    task automatic t_shape;
        wr(`TXPS_OFF_CTRL, 32'h14);
        chk("mode", TXPS_LEGACY_LBO, shape_mode);
        chk("coef", 32'h1122d7, coef);
        chk("atten", 32'h2, atten);
        wr(`TXPS_OFF_CTRL, 32'h10);
        chk("atten", 32'h0, atten);
        wr(`TXPS_OFF_LEGACY, 32'h00039c);
        chk("coef", 32'h00039c, coef);
        wr(`TXPS_OFF_CTRL, 32'h04);
        wr(`TXPS_OFF_LEGACY, 32'h1122d7);
        chk("coef", 32'h1122d7, coef);
        wr(`TXPS_OFF_CTRL, 32'h15);
        chk("mode", TXPS_TABLE, shape_mode);
        chk("atten", 32'h2, atten);
        wr(8'h64, 32'hef);
        rd(8'h64);
        chk("amp10", 32'hffffffef, rd_data);
        wr(8'h40, 32'h3f);
        wr(8'h60, 32'hfc);
        rd(8'h60);
        chk("amp9", 32'hfffffffc, rd_data);
    endtask
    // First sample of a table pulse and alternating mark polarity
    task automatic t_level;
        logic first_a;
        syms(1);
        @(posedge clock);
        @(negedge clock);
        first_a = la;
        chk("pulse rails", 32'h1, {31'h0, la ^ lb});
        chk("sample level", first_a ? 32'h3f : 32'hc1, {24'h0, level});
        syms(1);
        @(posedge clock);
        @(negedge clock);
        chk("mark polarity", 32'h1, {31'h0, la ^ first_a});
    endtask
    task automatic t_ones;
        wr(`TXPS_OFF_IRQ_MASK, 32'h3);
        syms(1);
        send_mark <= 1'b0;
        syms(31);
        lstat(32'h0);
        syms(1);
        lstat(32'h1);
        chk("irq", 32'h1, irq);
        rd(`TXPS_OFF_IRQ_STAT);
        chk("irq status", 32'h1, rd_data);
        chk("irq", 32'h0, irq);
        send_mark <= 1'b1;
        syms(1);
        lstat(32'h0);
        rd(`TXPS_OFF_IRQ_STAT);
        chk("irq status", 32'h1, rd_data);
    endtask
    task automatic t_hc;
        syms(1);
        short_load <= 1'b1;
        syms(2);
        lstat(32'h0);
        syms(1);
        lstat(32'h6);
        chk("oe", 32'h0, oe);
        wr(`TXPS_OFF_CTRL, 32'h2);
        chk("oe", 32'h1, oe);
        wr(`TXPS_OFF_CTRL, 32'h0);
        short_load <= 1'b0;
        lstat(32'h0);
        chk("oe", 32'h1, oe);
        rd(`TXPS_OFF_IRQ_STAT);
        chk("irq status", 32'h2, rd_data);
    endtask
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Main sequence and watchdog
    initial begin
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        @(negedge clock);
        @(negedge clock);
        t_reset();
        t_shape();
        t_level();
        t_ones();
        t_hc();
        give_verdict();
    end
    initial begin
        #500000;
        err_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
